// file: hdl/uxc_ctrl.sv
// Purpose: Channel-0 go/halt/resume control, 24-bit byte counter and endpoint-0 handshake and toggle control.
// Assumes: Link engine reports transaction start/end as one-cycle pulses synchronous to clk.
// Notes:   Register reads answer one cycle after the read strobe.
// Overview of operation
// RQ1: Go bit starts, zero halts, reads busy.
// RQ2: Auto-stage enable at go starts sequencer.
// RQ3: Count exhausted sets done, clears go.
// RQ4: Error flags clear go automatically.
// RQ5: Halt finishes transaction, then sets flag.
// RQ6: Halt keeps count and settings for resume.
// RQ7: Software clears buffer before fresh transfer.
// RQ8: Count is 24 bits in three bytes.
// RQ9: Software loads data-stage length when sequencing.
// RQ10: Mid read freezes low-byte readback value.
// RQ11: Software reads mid, high, then low.
// RQ12: Zero count OUT sends zero-length packet.
// RQ13: Count 0xFFFFF runs unlimited, no done.
// RQ14: Nak-after-success sets matching hold-off bit.
// RQ15: Short-packet bit sends partial, then clears.
// RQ16: IN hold-off answers IN with NAK.
// RQ17: OUT hold-off answers OUT with NAK.
// RQ18: Setup received sets hold-offs, clears halts.
// RQ19: Halt reply beats hold-off same direction.
// RQ20: Handshake changes apply from next transaction.
// RQ21: Software keeps hold-offs while setup pending.
// RQ22: Toggle states readable; IN force-one works.
// RQ23: Direction OUT 00b, IN 10b; mismatch silent.
// RQ24: Toggle bit seeds and reports data toggle.
// RQ25: Toggle force-zero and OUT force commands.
// RQ26: Reserved and command bits read zero.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
`include "uxc_map.svh"
module uxc_ctrl
  import uxc_pkg::*;
#(
  parameter int CNT_W = 24
)
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire uxc_pkg::uxc_bus_type bus,
  output var  logic [7:0]        rdata,
  input  wire logic              tr_start,
  input  wire logic              tr_end,
  input  wire logic              tr_ok,
  input  wire logic              tr_in,
  input  wire logic [CNT_W-1:0]  tr_bytes,
  input  wire logic              tr_fault,
  input  wire logic              port_fault,
  input  wire logic              setup_seen,
  input  wire logic              tok_valid,
  input  wire logic              tok_in,
  output var  uxc_pkg::uxc_hs_type hs_reply,
  output var  logic              go_out,
  output var  logic              seq_start,
  output var  logic              zlp_send,
  output var  logic              short_send,
  output var  logic              done_flag,
  output var  logic              halt_flag,
  output var  logic              toggle_out
);
  // Width must match the three byte registers.
  if (CNT_W != 24) $error("uxc_ctrl: CNT_W must be 24");

  logic              go_r;          // Transfer-go bit.
  logic              busy_r;        // A transaction is on the wire.
  logic              halt_pend_r;   // Software halted while busy.
  logic [CNT_W-1:0]  cnt_r;         // Remaining byte count.
  logic [7:0]        low_frz_r;     // Low byte frozen by a mid read.
  logic [7:0]        seq_cfg_r;     // Sequencer config byte.
  logic [7:0]        dir_cfg_r;     // Direction config byte.
  logic              tog_r;         // Channel toggle bit.
  logic [7:0]        hs_r;          // Handshake control as written.
  logic [7:0]        hs_act_r;      // Handshake control sampled per transaction.
  logic              in_tog_r;      // IN data toggle.
  logic              out_tog_r;     // OUT data toggle.
  logic              done_r;        // Sticky done flag.
  logic              halt_r;        // Sticky halt flag.
  logic              wr_go;         // Write to the run control register.
  logic              unlimited;     // Count programmed as unlimited.
  logic              fin;           // Transfer complete this cycle.
  logic [CNT_W-1:0]  cnt_left;      // Count after this transaction.

  assign wr_go     = bus.wr && bus.addr == `UXC_OFS_RUN_CTRL;
  assign unlimited = cnt_r == `UXC_CNT_UNLIMITED;
  assign cnt_left  = (tr_bytes >= cnt_r) ? '0 : cnt_r - tr_bytes;
  // Only a counted transfer finishes by count; the unlimited code never does.
  assign fin       = tr_end && tr_ok && !unlimited && cnt_left == '0; // [RQ3] [RQ13]

  // Go bit: set by software, cleared by software, completion or fault.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      go_r <= 1'b0;
    end
    else if (fin || tr_fault || port_fault)
    begin
      // Hardware clears win over a same-cycle write, since the transfer is over.
      go_r <= 1'b0; // [RQ3] [RQ4]
    end
    else if (wr_go)
    begin
      go_r <= bus.wdata[`UXC_BIT_GO]; // [RQ1] [RQ6]
    end
  end

  // Transaction tracking and halt bookkeeping.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      busy_r      <= 1'b0;
      halt_pend_r <= 1'b0;
      halt_r      <= 1'b0;
      done_r      <= 1'b0;
    end
    else
    begin
      if (tr_start)
        busy_r <= 1'b1;
      else if (tr_end)
        busy_r <= 1'b0;
      // A halt during a transaction is reported when it ends.
      if (wr_go && !bus.wdata[`UXC_BIT_GO] && go_r && busy_r)
        halt_pend_r <= 1'b1; // [RQ5]
      else if (tr_end)
        halt_pend_r <= 1'b0;
      if (tr_end && halt_pend_r)
        halt_r <= 1'b1; // [RQ5]
      else if (bus.wr && bus.addr == `UXC_OFS_EVENTS && bus.wdata[0])
        halt_r <= 1'b0;
      if (fin)
        done_r <= 1'b1; // [RQ3]
      else if (bus.wr && bus.addr == `UXC_OFS_EVENTS && bus.wdata[7])
        done_r <= 1'b0;
    end
  end

  // Byte counter; it is untouched by a halt so a resume carries on.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r <= '0;
    end
    else if (tr_end && tr_ok && !unlimited)
    begin
      cnt_r <= cnt_left; // [RQ6] [RQ13]
    end
    else if (bus.wr && bus.addr == `UXC_OFS_CNT_HIGH)
    begin
      cnt_r[23:16] <= bus.wdata; // [RQ8]
    end
    else if (bus.wr && bus.addr == `UXC_OFS_CNT_MID)
    begin
      cnt_r[15:8] <= bus.wdata; // [RQ8]
    end
    else if (bus.wr && bus.addr == `UXC_OFS_CNT_LOW)
    begin
      cnt_r[7:0] <= bus.wdata; // [RQ8]
    end
  end

  // Low byte snapshot taken on a mid read, so a multi-byte read is coherent.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      low_frz_r <= `UXC_RESET_BYTE;
    else if (bus.rd && bus.addr == `UXC_OFS_CNT_MID)
      low_frz_r <= cnt_r[7:0]; // [RQ10]
  end

  // Config bytes and channel toggle.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      seq_cfg_r <= `UXC_RESET_BYTE;
      dir_cfg_r <= `UXC_RESET_BYTE;
      tog_r     <= 1'b0;
    end
    else
    begin
      if (bus.wr && bus.addr == `UXC_OFS_SEQ_CFG)
        seq_cfg_r <= bus.wdata & 8'h07;
      if (bus.wr && bus.addr == `UXC_OFS_DIR_CFG)
        dir_cfg_r <= bus.wdata & 8'hCF;
      // Completion reports the resulting toggle; otherwise software seeds it.
      if (tr_end && tr_ok)
        tog_r <= ~tog_r; // [RQ24]
      else if (wr_go)
        tog_r <= bus.wdata[`UXC_BIT_TOGGLE]; // [RQ24]
    end
  end

  // Endpoint-0 handshake control byte.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      hs_r <= `UXC_RESET_BYTE;
    end
    else
    begin
      if (bus.wr && bus.addr == `UXC_OFS_EP0_HS)
        hs_r <= bus.wdata & `UXC_HS_MASK; // [RQ26]
      // Hardware updates take precedence over a same-cycle write.
      if (setup_seen)
      begin
        hs_r[`UXC_BIT_IN_NAK]    <= 1'b1; // [RQ18]
        hs_r[`UXC_BIT_OUT_NAK]   <= 1'b1;
        hs_r[`UXC_BIT_IN_STALL]  <= 1'b0;
        hs_r[`UXC_BIT_OUT_STALL] <= 1'b0;
      end
      else if (tr_end && tr_ok && hs_r[`UXC_BIT_NAK_AUTO])
      begin
        if (tr_in)
          hs_r[`UXC_BIT_IN_NAK] <= 1'b1; // [RQ14]
        else
          hs_r[`UXC_BIT_OUT_NAK] <= 1'b1; // [RQ14]
      end
      if (tr_end && tr_ok && tr_in && hs_act_r[`UXC_BIT_SHORT])
        hs_r[`UXC_BIT_SHORT] <= 1'b0; // [RQ15]
    end
  end

  // Snapshot used for the running transaction; refreshed only between transactions.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      hs_act_r <= `UXC_RESET_BYTE;
    else if (!busy_r)
      hs_act_r <= hs_r; // [RQ20]
  end

  // Data toggles for endpoint 0.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      in_tog_r  <= 1'b0;
      out_tog_r <= 1'b0;
    end
    else
    begin
      if (bus.wr && bus.addr == `UXC_OFS_EP0_TOG && bus.wdata[`UXC_BIT_IN_TSET])
        in_tog_r <= 1'b1; // [RQ22]
      else if (bus.wr && bus.addr == `UXC_OFS_EP0_TOG && bus.wdata[`UXC_BIT_IN_TCLR])
        in_tog_r <= 1'b0; // [RQ25]
      else if (tr_end && tr_ok && tr_in)
        in_tog_r <= ~in_tog_r;
      if (bus.wr && bus.addr == `UXC_OFS_EP0_TOG && bus.wdata[`UXC_BIT_OUT_TSET])
        out_tog_r <= 1'b1; // [RQ25]
      else if (bus.wr && bus.addr == `UXC_OFS_EP0_TOG && bus.wdata[`UXC_BIT_OUT_TCLR])
        out_tog_r <= 1'b0; // [RQ25]
      else if (tr_end && tr_ok && !tr_in)
        out_tog_r <= ~out_tog_r;
    end
  end

  // Handshake decision for an incoming token, registered.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      hs_reply <= UXC_HS_NONE;
    else if (!tok_valid)
      hs_reply <= UXC_HS_NONE;
    else if (tok_in ? dir_cfg_r[7:6] != `UXC_DIR_IN : dir_cfg_r[7:6] != `UXC_DIR_OUT)
      hs_reply <= UXC_HS_NONE; // [RQ23]
    else if (tok_in ? hs_act_r[`UXC_BIT_IN_STALL] : hs_act_r[`UXC_BIT_OUT_STALL])
      hs_reply <= UXC_HS_STALL; // [RQ19]
    else if (tok_in ? hs_act_r[`UXC_BIT_IN_NAK] : hs_act_r[`UXC_BIT_OUT_NAK])
      hs_reply <= UXC_HS_NAK; // [RQ16] [RQ17]
    else
      hs_reply <= UXC_HS_ACK;
  end

  // Outputs to the link engine, all registered.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      go_out     <= 1'b0;
      seq_start  <= 1'b0;
      zlp_send   <= 1'b0;
      short_send <= 1'b0;
      done_flag  <= 1'b0;
      halt_flag  <= 1'b0;
      toggle_out <= 1'b0;
    end
    else
    begin
      go_out     <= go_r; // [RQ1]
      seq_start  <= wr_go && bus.wdata[`UXC_BIT_GO] && !go_r && seq_cfg_r[`UXC_BIT_AUTO_EN]; // [RQ2]
      zlp_send   <= go_r && cnt_r == '0 && dir_cfg_r[7:6] == `UXC_DIR_OUT; // [RQ12]
      short_send <= hs_act_r[`UXC_BIT_SHORT]; // [RQ15]
      done_flag  <= done_r;
      halt_flag  <= halt_r;
      toggle_out <= tog_r;
    end
  end

  // Register read port: data stand in the cycle after the strobe.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rdata <= `UXC_RESET_BYTE;
    else if (!bus.rd)
      rdata <= `UXC_RESET_BYTE;
    else if (bus.addr == `UXC_OFS_RUN_CTRL)
      rdata <= {3'h0, tog_r, 3'h0, go_r}; // [RQ1] [RQ26]
    else if (bus.addr == `UXC_OFS_CNT_HIGH)
      rdata <= cnt_r[23:16];
    else if (bus.addr == `UXC_OFS_CNT_MID)
      rdata <= cnt_r[15:8];
    else if (bus.addr == `UXC_OFS_CNT_LOW)
      rdata <= low_frz_r; // [RQ10]
    else if (bus.addr == `UXC_OFS_EP0_HS)
      rdata <= hs_r;
    else if (bus.addr == `UXC_OFS_EP0_TOG)
      rdata <= {in_tog_r, 3'h0, out_tog_r, 3'h0}; // [RQ22] [RQ26]
    else if (bus.addr == `UXC_OFS_SEQ_CFG)
      rdata <= seq_cfg_r;
    else if (bus.addr == `UXC_OFS_DIR_CFG)
      rdata <= dir_cfg_r;
    else if (bus.addr == `UXC_OFS_EVENTS)
      rdata <= {done_r, 6'h00, halt_r};
    else
      rdata <= `UXC_RESET_BYTE;
  end

  // Completion must drop the go bit one edge later.
  go_clear_a: assert property (@(posedge clk) disable iff (rst) fin |=> !go_r) // [RQ3]
    else $error("go bit not cleared on completion");
  // A fault must drop the go bit.
  fault_clear_a: assert property (@(posedge clk) disable iff (rst) (tr_fault || port_fault) |=> !go_r) // [RQ4]
    else $error("go bit not cleared on fault");
  // Unlimited count never reports done.
  unlim_done_a: assert property (@(posedge clk) disable iff (rst) (unlimited && !done_r) |=> !done_r) // [RQ13]
    else $error("done set for unlimited count");
  // Setup forces hold-offs and clears halts.
  setup_hs_a: assert property (@(posedge clk) disable iff (rst) setup_seen |=> // [RQ18]
    hs_r[`UXC_BIT_IN_NAK] && hs_r[`UXC_BIT_OUT_NAK] && !hs_r[`UXC_BIT_IN_STALL] && !hs_r[`UXC_BIT_OUT_STALL])
    else $error("setup did not force handshake bits");
  // Halt reply beats hold-off.
  stall_prio_a: assert property (@(posedge clk) disable iff (rst) // [RQ19]
    (tok_valid && tok_in && dir_cfg_r[7:6] == `UXC_DIR_IN && hs_act_r[`UXC_BIT_IN_STALL]) |=> hs_reply == UXC_HS_STALL)
    else $error("stall not prioritised");
  // IN hold-off answers NAK when no halt.
  in_nak_a: assert property (@(posedge clk) disable iff (rst) // [RQ16]
    (tok_valid && tok_in && dir_cfg_r[7:6] == `UXC_DIR_IN && !hs_act_r[`UXC_BIT_IN_STALL] && hs_act_r[`UXC_BIT_IN_NAK])
    |=> hs_reply == UXC_HS_NAK)
    else $error("IN hold-off not honoured");
  // Snapshot holds during a transaction.
  snap_hold_a: assert property (@(posedge clk) disable iff (rst) busy_r |=> $stable(hs_act_r)) // [RQ20]
    else $error("handshake changed mid transaction");
  // Mid read freezes the low byte seen next.
  low_freeze_a: assert property (@(posedge clk) disable iff (rst) // [RQ10]
    (bus.rd && bus.addr == `UXC_OFS_CNT_MID) |=> low_frz_r == $past(cnt_r[7:0]))
    else $error("low byte not frozen");
  // IN token while the direction is OUT gets no handshake.
  dir_silent_a: assert property (@(posedge clk) disable iff (rst) // [RQ23]
    (tok_valid && tok_in && dir_cfg_r[7:6] == `UXC_DIR_OUT) |=> hs_reply == UXC_HS_NONE)
    else $error("mismatched token answered");
endmodule
`default_nettype wire

// file: hdl/uxc_map.svh
// Purpose: Register offsets, field positions and reset values of the channel-0 transfer control block.
// Assumes: Byte-wide register port with byte addresses.
// Notes:   Definitions only.
`ifndef UXC_MAP_SVH
`define UXC_MAP_SVH
`define UXC_OFS_RUN_CTRL    8'h66
`define UXC_OFS_CNT_HIGH    8'h67
`define UXC_OFS_CNT_MID     8'h68
`define UXC_OFS_CNT_LOW     8'h69
`define UXC_OFS_EP0_HS      8'h6A
`define UXC_OFS_EP0_TOG     8'h6B
`define UXC_OFS_SEQ_CFG     8'h64
`define UXC_OFS_DIR_CFG     8'h61
`define UXC_OFS_EVENTS      8'h10
`define UXC_BIT_GO          0
`define UXC_BIT_TOGGLE      4
`define UXC_BIT_AUTO_EN     0
`define UXC_BIT_NO_DATA     1
`define UXC_BIT_NAK_AUTO    6
`define UXC_BIT_SHORT       5
`define UXC_BIT_IN_NAK      3
`define UXC_BIT_IN_STALL    2
`define UXC_BIT_OUT_NAK     1
`define UXC_BIT_OUT_STALL   0
`define UXC_BIT_IN_TSTAT    7
`define UXC_BIT_IN_TSET     5
`define UXC_BIT_IN_TCLR     4
`define UXC_BIT_OUT_TSTAT   3
`define UXC_BIT_OUT_TSET    1
`define UXC_BIT_OUT_TCLR    0
`define UXC_DIR_OUT         2'h0
`define UXC_DIR_IN          2'h2
`define UXC_CNT_UNLIMITED   24'h0FFFFF
`define UXC_RESET_BYTE      8'h00
`define UXC_HS_MASK         8'h6F
`endif

// file: hdl/uxc_pkg.sv
// Purpose: Types shared by the channel-0 transfer control block.
// Assumes: Used together with uxc_map.svh.
// Notes:   Types only; numbers live in the map header.
package uxc_pkg;
  // Register port request from software.
  typedef struct packed {
    logic [7:0] addr;   // Byte address.
    logic [7:0] wdata;  // Write data.
    logic       wr;     // Write strobe.
    logic       rd;     // Read strobe.
  } uxc_bus_type;
  // Reply the block gives to the link engine for endpoint 0.
  typedef enum logic [1:0] {
    UXC_HS_ACK   = 2'b00,
    UXC_HS_NAK   = 2'b01,
    UXC_HS_STALL = 2'b10,
    UXC_HS_NONE  = 2'b11
  } uxc_hs_type;
  // Channel-0 run states.
  typedef enum logic [1:0] {
    UXC_IDLE     = 2'b00,
    UXC_RUN      = 2'b01,
    UXC_DRAIN    = 2'b10
  } uxc_state_type;
endpackage

// file: tb/uxc_link_model.sv
// Purpose: Behavioural link engine and far-side bus partner that produces transaction and token events.
// Assumes: One clock; every event is a one-cycle pulse launched just after a rising edge.
// Notes:   The byte count is only meaningful beside the end pulse; elsewhere it shows the inverse value.
`timescale 1ns/1ns
`default_nettype none
module uxc_link_model
(
  input  wire logic        clk,
  output var  logic        tr_start,
  output var  logic        tr_end,
  output var  logic        tr_ok,
  output var  logic        tr_in,
  output wire logic [23:0] tr_bytes,
  output var  logic        tr_fault,
  output var  logic        port_fault,
  output var  logic        setup_seen,
  output var  logic        tok_valid,
  output var  logic        tok_in
);
  logic [23:0] byt; // Bytes moved by the last transaction.

  // Outside the end pulse the count is not held, so the design cannot lean on a stale value.
  assign tr_bytes = tr_end ? byt : ~byt;

  // Every output but the byte count starts low at time zero.
  initial
  begin
    {tr_start, tr_end, tr_ok, tr_in, tr_fault, port_fault, setup_seen, tok_valid, tok_in} = 9'h000;
    byt = 24'h000000;
  end

  // Opens a transaction on the wire.
  task automatic start;
    @(posedge clk);
    tr_start <= 1'b1;
    @(posedge clk);
    tr_start <= 1'b0;
  endtask

  // Closes a transaction with its outcome.
  task automatic finish(input logic [23:0] n, input logic in_d, input logic ok);
    @(posedge clk);
    byt    <= n;
    tr_in  <= in_d;
    tr_ok  <= ok;
    tr_end <= 1'b1;
    @(posedge clk);
    tr_end <= 1'b0;
    tr_ok  <= ~ok;
  endtask

  // A whole transaction; gap sets a prompt or a slow partner.
  task automatic xfer(input logic [23:0] n, input logic in_d, input logic ok, input int gap);
    start();
    repeat (gap) @(posedge clk);
    finish(n, in_d, ok);
  endtask

  // Pulses a fault (0), a port fault (1) or a received setup (2).
  task automatic ev(input int k);
    @(posedge clk);
    tr_fault   <= (k == 0);
    port_fault <= (k == 1);
    setup_seen <= (k == 2);
    @(posedge clk);
    {tr_fault, port_fault, setup_seen} <= 3'h0;
  endtask

  // A token of the given direction arrives at endpoint 0.
  task automatic token(input logic in_d);
    @(posedge clk);
    tok_valid <= 1'b1;
    tok_in    <= in_d;
    @(posedge clk);
    tok_valid <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: tb/uxc_ctrl_tb.sv
// Purpose: Self-checking bench for the channel-0 transfer control block.
// Assumes: Reads answer one cycle after the strobe; reply to a token stands one cycle.
// Notes:   Expected reads and replies are queued by the driver and checked by a watcher.
`timescale 1ns/1ns
`default_nettype none
module uxc_ctrl_tb;
  import uxc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  uxc_bus_type bus = '0;                  // Register port request.
  logic [7:0] rdata;                      // Read data.
  uxc_hs_type hs_reply;                   // Endpoint reply.
  logic go_out, seq_start, zlp_send, short_send, done_flag, halt_flag, toggle_out;
  logic tr_start, tr_end, tr_ok, tr_in, tr_fault, port_fault, setup_seen, tok_valid, tok_in;
  logic [23:0] tr_bytes;                  // Bytes moved.
  logic [7:0] rq[$];                      // Expected read data.
  uxc_hs_type hq[$];                      // Expected replies.
  logic rpend = 1'b0;                     // Read answer due.
  logic tpend = 1'b0;                     // Reply due.
  logic seq_seen = 1'b0;                  // Sequencer start observed.
  int num_errors = 0;
  int checks = 0;
  int seed = 64481;
  logic [23:0] v;

  always #2 clk = ~clk;

  uxc_ctrl uxc_ctrl_inst (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .tr_start(tr_start),
    .tr_end(tr_end), .tr_ok(tr_ok), .tr_in(tr_in), .tr_bytes(tr_bytes), .tr_fault(tr_fault),
    .port_fault(port_fault), .setup_seen(setup_seen), .tok_valid(tok_valid), .tok_in(tok_in),
    .hs_reply(hs_reply), .go_out(go_out), .seq_start(seq_start), .zlp_send(zlp_send),
    .short_send(short_send), .done_flag(done_flag), .halt_flag(halt_flag), .toggle_out(toggle_out));

  uxc_link_model uxc_link_model_inst (.clk(clk), .tr_start(tr_start), .tr_end(tr_end), .tr_ok(tr_ok),
    .tr_in(tr_in), .tr_bytes(tr_bytes), .tr_fault(tr_fault), .port_fault(port_fault),
    .setup_seen(setup_seen), .tok_valid(tok_valid), .tok_in(tok_in));

  // One compare for every kind of result; an unknown never matches.
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic give_verdict;
    if (num_errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Register write: one strobe cycle, dropped at the edge that takes it.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  // Register read: the expectation is queued for the watcher.
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    rq.push_back(e);
    @(posedge clk);
    bus.rd <= 1'b0;
  endtask

  // Lets registered flags settle before a level is looked at.
  task automatic settle;
    repeat (4) @(posedge clk);
    #1;
  endtask

  // Token after the handshake settings have had time to take hold.
  task automatic tok(input logic in_d, input uxc_hs_type e);
    repeat (2) @(posedge clk);
    hq.push_back(e);
    uxc_link_model_inst.token(in_d);
  endtask

  task automatic load(input logic [23:0] n);
    wr(8'h67, n[23:16]);
    wr(8'h68, n[15:8]);
    wr(8'h69, n[7:0]);
  endtask

  // Answers stand one cycle, so they are looked at mid-cycle after the taking edge.
  always @(posedge clk)
  begin
    rpend <= bus.rd;
    tpend <= tok_valid;
    if (seq_start) seq_seen <= 1'b1;
  end

  always @(negedge clk)
  begin
    if (rpend) chk(rdata, rq.pop_front());
    if (tpend) chk({6'h00, hs_reply}, {6'h00, hq.pop_front()});
  end

  // A hang is cut short well beyond the expected run.
  initial
  begin
    #200000;
    num_errors++;
    give_verdict();
  end

  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (int a = 'h66; a <= 'h6B; a++) rd(a[7:0], 8'h00);
    rd(8'h7F, 8'h00);
    repeat (3)
    begin
      v = 24'($random(seed));
      load(v);
      rd(8'h68, v[15:8]);
      rd(8'h67, v[23:16]);
      rd(8'h69, v[7:0]);
    end
    load(24'h000010);
    wr(8'h66, 8'h01);
    settle();
    chk({7'h00, go_out}, 8'h01);
    rd(8'h66, 8'h01);
    uxc_link_model_inst.xfer(24'h000004, 1'b0, 1'b1, 2);
    settle();
    chk({7'h00, toggle_out}, 8'h01);
    uxc_link_model_inst.start();
    wr(8'h66, 8'h00);
    uxc_link_model_inst.finish(24'h000004, 1'b0, 1'b1);
    settle();
    chk({6'h00, go_out, halt_flag}, 8'h01);
    rd(8'h68, 8'h00);
    rd(8'h69, 8'h08);
    wr(8'h66, 8'h01);
    uxc_link_model_inst.xfer(24'h000008, 1'b0, 1'b1, 6);
    settle();
    chk({6'h00, go_out, done_flag}, 8'h01);
    rd(8'h10, 8'h81);
    wr(8'h10, 8'h81);
    settle();
    chk({6'h00, done_flag, halt_flag}, 8'h00);
    load(24'h000010);
    for (int k = 0; k < 2; k++)
    begin
      wr(8'h66, 8'h01);
      uxc_link_model_inst.ev(k);
      settle();
      chk({7'h00, go_out}, 8'h00);
    end
    chk({7'h00, seq_seen}, 8'h00);
    wr(8'h64, 8'h01);
    rd(8'h64, 8'h01);
    wr(8'h66, 8'h01);
    settle();
    chk({7'h00, seq_seen}, 8'h01);
    wr(8'h66, 8'h00);
    wr(8'h64, 8'h00);
    load(24'h000000);
    wr(8'h66, 8'h01);
    settle();
    chk({7'h00, zlp_send}, 8'h01);
    wr(8'h61, 8'h80);
    settle();
    chk({7'h00, zlp_send}, 8'h00);
    wr(8'h66, 8'h00);
    wr(8'h10, 8'h81);
    load(24'h0FFFFF);
    wr(8'h66, 8'h01);
    uxc_link_model_inst.xfer(24'h000040, 1'b1, 1'b1, 1);
    settle();
    chk({6'h00, go_out, done_flag}, 8'h02);
    wr(8'h66, 8'h00);
    wr(8'h61, 8'h80);
    wr(8'h6A, 8'h08);
    tok(1'b1, UXC_HS_NAK);
    wr(8'h6A, 8'h0C);
    tok(1'b1, UXC_HS_STALL);
    tok(1'b0, UXC_HS_NONE);
    wr(8'h61, 8'h00);
    wr(8'h6A, 8'h02);
    tok(1'b0, UXC_HS_NAK);
    wr(8'h6A, 8'h03);
    tok(1'b0, UXC_HS_STALL);
    wr(8'h6A, 8'h00);
    tok(1'b1, UXC_HS_NONE);
    uxc_link_model_inst.start();
    wr(8'h6A, 8'h02);
    tok(1'b0, UXC_HS_ACK);
    uxc_link_model_inst.finish(24'h000008, 1'b0, 1'b1);
    tok(1'b0, UXC_HS_NAK);
    wr(8'h6A, 8'h05);
    uxc_link_model_inst.ev(2);
    settle();
    rd(8'h6A, 8'h0A);
    wr(8'h6A, 8'h60);
    settle();
    chk({7'h00, short_send}, 8'h01);
    uxc_link_model_inst.xfer(24'h000003, 1'b1, 1'b1, 1);
    settle();
    rd(8'h6A, 8'h48);
    wr(8'h6B, 8'h22);
    rd(8'h6B, 8'h88);
    wr(8'h6B, 8'h00);
    rd(8'h6B, 8'h88);
    wr(8'h6B, 8'h11);
    rd(8'h6B, 8'h00);
    settle();
    give_verdict();
  end
endmodule
`default_nettype wire
